// >>> rtl/link_ctl_pack.sv
// Purpose: pack stored link control fields into the 16-bit read value
// Assumes: fields already held in flip-flops
// Notes: fixed-zero bits are tied here so reads never show stale data
`timescale 1ns/1ps
module link_ctl_pack
    import link_ctl_pkg::*;
(
    input wire link_ctl_fields_t i_fields,
    output logic [15:0] o_word
);

    // ***************************************
    // read word assembly
    // ***************************************
    // every bit not stored is constant zero
    always_comb begin
        o_word = 16'h0000;
        o_word[ASPM_MSB:ASPM_LSB] = i_fields.aspm;
        o_word[COMPLETION_BOUNDARY_POS] = 1'b0;
        o_word[LINK_DISABLE_POS] = i_fields.link_disable_bit;
        o_word[LINK_RETRAIN_POS] = 1'b0;
        o_word[COMMON_CLOCK_POS] = i_fields.common_clock_bit;
        o_word[EXTENDED_SYNC_POS] = i_fields.extended_sync_bit;
        o_word[CLOCK_PWR_MGMT_POS] = 1'b0;
    end

endmodule : link_ctl_pack

// >>> rtl/link_ctl_pkg.sv
// Purpose: constants and types for the per-port link control register block
// Assumes: one 20 MHz core clock, asynchronous active-low port reset
// Notes: register reached over Avalon-MM, one aligned 32-bit word per register
package link_ctl_pkg;

    // ***************************************
    // register map
    // ***************************************
    localparam logic [11:0] LINK_CONTROL_OFFSET = 12'h050;
    localparam logic [11:0] SWITCH_CONTROL_OFFSET = 12'h400;
    localparam logic [15:0] LINK_CONTROL_RESET = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;

    // ***************************************
    // field positions
    // ***************************************
    localparam int ASPM_LSB = 0;
    localparam int ASPM_MSB = 1;
    localparam int COMPLETION_BOUNDARY_POS = 3;
    localparam int LINK_DISABLE_POS = 4;
    localparam int LINK_RETRAIN_POS = 5;
    localparam int COMMON_CLOCK_POS = 6;
    localparam int EXTENDED_SYNC_POS = 7;
    localparam int CLOCK_PWR_MGMT_POS = 8;
    localparam int REGISTER_UNLOCK_POS = 0;

    // ***************************************
    // power entry encodings and reset values
    // ***************************************
    localparam logic [1:0] ASPM_DISABLED = 2'h0;
    localparam logic [1:0] ASPM_L0S = 2'h1;
    localparam logic [1:0] ASPM_L1 = 2'h2;
    localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
    localparam logic ASPM_BIT_L0S = 1'b0;
    localparam logic COMMON_CLOCK_RESET = 1'b0;
    localparam logic UNLOCK_RESET = 1'b0;

    // stored writable fields of the link control word
    typedef struct packed {
        logic [1:0] aspm;
        logic link_disable_bit;
        logic common_clock_bit;
        logic extended_sync_bit;
    } link_ctl_fields_t;

    // controls presented to the training logic
    typedef struct packed {
        logic l0s_entry_en;
        logic l1_entry_en;
        logic link_disable;
        logic retrain;
        logic common_clock;
        logic extended_sync;
    } link_train_ctl_t;

endpackage : link_ctl_pkg

// >>> rtl/link_ctl_reg.sv
// Purpose: per-port link control register with Avalon-MM slave access
// Assumes: i_is_upstream is static; EEPROM load is a one-cycle strobe
// Notes: one wait state on every access; training outputs are registered
`timescale 1ns/1ps
module link_ctl_reg
    import link_ctl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    // avalon-mm slave
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // port configuration and serial EEPROM load
    input wire logic i_is_upstream,
    input wire logic i_eeprom_load,
    input wire logic [1:0] i_eeprom_aspm,
    // controls to the training state machine
    output logic o_l0s_entry_en,
    output logic o_l1_entry_en,
    output logic o_link_disable,
    output logic o_retrain,
    output logic o_common_clock,
    output logic o_extended_sync
);

    // ***************************************
    // state
    // ***************************************
    link_ctl_fields_t fields_r;
    link_ctl_fields_t fields_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic ack_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    link_train_ctl_t train_r;
    link_train_ctl_t train_nxt;
    logic [15:0] read_word;

    // ***************************************
    // address decode
    // ***************************************
    // the access completes on the cycle ack_r is high; waitrequest drops then
    wire req = i_avs_read | i_avs_write;
    wire take = req & ack_r;
    wire ack_nxt = req & ~ack_r;
    wire hit_lctl = (i_avs_address == LINK_CONTROL_OFFSET);
    wire hit_switch_control_register = (i_avs_address == SWITCH_CONTROL_OFFSET);
    wire wr_lctl = take & i_avs_write & hit_lctl;
    wire wr_switch_control_register = take & i_avs_write & hit_switch_control_register;
    wire wr_lo = wr_lctl & i_avs_byteenable[0];
    wire wr_hi = wr_lctl & i_avs_byteenable[1];
    wire retrain_write = wr_lo & i_avs_writedata[LINK_RETRAIN_POS];
    // upstream retrain only passes while unlocked
    wire retrain_allowed = ~i_is_upstream | unlock_r;

    // ***************************************
    // field update
    // ***************************************
    // bits 2, 3, 5 and 8..15 have no storage; writes to them vanish except bit 5, which raises the retrain pulse
    always_comb begin
        fields_nxt = fields_r;
        unlock_nxt = unlock_r;
        if (i_eeprom_load) begin
            fields_nxt.aspm = i_eeprom_aspm;
        end
        if (wr_lo) begin
            fields_nxt.aspm = i_avs_writedata[ASPM_MSB:ASPM_LSB];
            fields_nxt.link_disable_bit = i_avs_writedata[LINK_DISABLE_POS];
            fields_nxt.common_clock_bit = i_avs_writedata[COMMON_CLOCK_POS];
            fields_nxt.extended_sync_bit = i_avs_writedata[EXTENDED_SYNC_POS];
        end
        if (wr_switch_control_register && i_avs_byteenable[0]) begin
            unlock_nxt = i_avs_writedata[REGISTER_UNLOCK_POS];
        end
    end

    // high byte holds only fixed zeros, so wr_hi has nothing to store
    wire unused_hi = wr_hi;

    // ***************************************
    // training controls
    // ***************************************
    // built from the next field values so a retrain write with new settings
    // presents both together in the same cycle
    always_comb begin
        train_nxt.l0s_entry_en = fields_nxt.aspm[ASPM_BIT_L0S];
        train_nxt.l1_entry_en = fields_nxt.aspm[ASPM_MSB];
        // upstream forces link_disable low; the stored bit still reads back
        train_nxt.link_disable = fields_nxt.link_disable_bit & ~i_is_upstream;
        train_nxt.retrain = retrain_write & retrain_allowed;
        train_nxt.common_clock = fields_nxt.common_clock_bit;
        train_nxt.extended_sync = fields_nxt.extended_sync_bit;
    end

    // ***************************************
    // read data
    // ***************************************
    link_ctl_pack u_pack (
        .i_fields(fields_r),
        .o_word(read_word)
    );

    // unmapped addresses answer zero rather than stalling the bus
    always_comb begin
        rdata_nxt = UNMAPPED_READ_VALUE;
        if (hit_lctl) begin
            rdata_nxt = {16'h0000, read_word};
        end else if (hit_switch_control_register) begin
            rdata_nxt = {31'h00000000, unlock_r};
        end
    end

    // ***************************************
    // registers
    // ***************************************
    // handshake: ack toggles on for one cycle per pending request
    // waitrequest has its own flop so the pin never sees a gate delay
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_r <= 1'b0;
            wait_r <= 1'b1;
        end else begin
            ack_r <= ack_nxt;
            wait_r <= ~ack_nxt;
        end
    end

    // read data captured a cycle ahead of the completing edge
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= UNMAPPED_READ_VALUE;
        end else if (req && !ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fields_r <= link_ctl_fields_t'(LINK_CONTROL_RESET[4:0]);
            unlock_r <= UNLOCK_RESET;
            train_r <= '0;
        end else begin
            fields_r <= fields_nxt;
            unlock_r <= unlock_nxt;
            train_r <= train_nxt;
        end
    end

    // ***************************************
    // outputs
    // ***************************************
    assign o_avs_waitrequest = wait_r;
    assign o_avs_readdata = rdata_r;
    assign o_l0s_entry_en = train_r.l0s_entry_en;
    assign o_l1_entry_en = train_r.l1_entry_en;
    assign o_link_disable = train_r.link_disable;
    assign o_retrain = train_r.retrain;
    assign o_common_clock = train_r.common_clock;
    assign o_extended_sync = train_r.extended_sync;

endmodule : link_ctl_reg

// >>> verif/link_ctl_properties.sv
// Purpose: concurrent checks on the link control register ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound into every link_ctl_reg instance
`timescale 1ns/1ps
module link_ctl_properties
    import link_ctl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_is_upstream,
    input wire logic i_eeprom_load,
    input wire logic [1:0] i_eeprom_aspm,
    input wire logic o_l0s_entry_en,
    input wire logic o_l1_entry_en,
    input wire logic o_link_disable,
    input wire logic o_retrain,
    input wire logic o_common_clock,
    input wire logic o_extended_sync
);
    // ****************************************
    // accepted accesses to the link word
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_wr;
        i_avs_write && !o_avs_waitrequest && i_avs_address == LINK_CONTROL_OFFSET
            && i_avs_byteenable[0];
    endsequence
    sequence s_rd;
        i_avs_read && !o_avs_waitrequest && i_avs_address == LINK_CONTROL_OFFSET;
    endsequence
    // unlock state mirrored from accepted switch control writes
    logic unlock_seen_r;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            unlock_seen_r <= 1'b0;
        end else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
            && i_avs_address == SWITCH_CONTROL_OFFSET) begin
            unlock_seen_r <= i_avs_writedata[REGISTER_UNLOCK_POS];
        end
    end
    // new field values reach the training side one edge after the write
    a_aspm_write: assert property (s_wr |=>
        {o_l1_entry_en, o_l0s_entry_en} == $past(i_avs_writedata[1:0])) else $error("aspm");
    // a link control write with byte lane 0 enabled in the same cycle wins over the serial load
    a_eeprom_load: assert property (i_eeprom_load && !(i_avs_write && !o_avs_waitrequest) |=>
        {o_l1_entry_en, o_l0s_entry_en} == $past(i_eeprom_aspm)) else $error("eeprom");
    a_disable_down: assert property (s_wr ##0 !i_is_upstream |=>
        o_link_disable == $past(i_avs_writedata[4])) else $error("disable down");
    a_disable_up: assert property (i_is_upstream |-> !o_link_disable)
        else $error("disable up");
    a_retrain_down: assert property (s_wr ##0 (i_avs_writedata[5] && !i_is_upstream)
        |=> o_retrain) else $error("retrain missing");
    a_retrain_cause: assert property (o_retrain |->
        $past(i_avs_write && !o_avs_waitrequest && i_avs_writedata[5]) ##1 !o_retrain)
        else $error("retrain pulse");
    // a locked upstream port never retrains, whatever software writes
    a_retrain_locked: assert property (i_is_upstream && !unlock_seen_r |-> !o_retrain)
        else $error("locked retrain");
    a_read_zero: assert property (s_rd |-> (o_avs_readdata & 32'hFFFFFF2C) == 32'h0)
        else $error("fixed bits");
    a_read_fields: assert property (s_rd |-> o_avs_readdata[7:6] ==
        {o_extended_sync, o_common_clock}) else $error("readback");
    a_new_fields: assert property (s_wr |=> o_extended_sync == $past(i_avs_writedata[7])
        && o_common_clock == $past(i_avs_writedata[6])) else $error("fields");
    // the slave answers one cycle after any request is raised
    a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("no answer");
endmodule : link_ctl_properties

bind link_ctl_reg link_ctl_properties link_ctl_properties_i (.*);

// >>> verif/tb.sv
// Purpose: random and corner tests of the link control register
// Assumes: bus answers under one wait state
// Notes: port side switched only under reset
`timescale 1ns/1ps
module tb;
    import link_ctl_pkg::*;
    logic i_clk, i_resetn, i_avs_read, i_avs_write, i_is_upstream, i_eeprom_load, unlock;
    logic [11:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, got, d;
    logic [3:0] i_avs_byteenable;
    logic [1:0] i_eeprom_aspm;
    logic o_avs_waitrequest, o_l0s_entry_en, o_l1_entry_en, o_link_disable;
    logic o_retrain, o_common_clock, o_extended_sync;
    int fails, num_checks, rt_cnt, exp_rt, cyc;
    link_ctl_reg link_ctl_reg_i (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest),
        .i_is_upstream(i_is_upstream),
        .i_eeprom_load(i_eeprom_load),
        .i_eeprom_aspm(i_eeprom_aspm),
        .o_l0s_entry_en(o_l0s_entry_en),
        .o_l1_entry_en(o_l1_entry_en),
        .o_link_disable(o_link_disable),
        .o_retrain(o_retrain),
        .o_common_clock(o_common_clock),
        .o_extended_sync(o_extended_sync)
    );
    // ****************************************
    // clock, pulse counter and hang guard
    // ****************************************
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (o_retrain === 1'b1) rt_cnt++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    function automatic logic [31:0] exp_word(input logic [31:0] v);
        return {16'h0000, v[15:0] & 16'h00D3}; // only bits 0,1,4,6,7 stored
    endfunction : exp_word
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
        {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, v};
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        got = o_avs_readdata;
        {i_avs_write, i_avs_read} <= 2'b00;
        @(posedge i_clk);
    endtask : bus
    task automatic step(input logic [31:0] v);
        bus(1'b1, LINK_CONTROL_OFFSET, v);
        if (v[5] && (!i_is_upstream || unlock)) exp_rt++;
        bus(1'b0, LINK_CONTROL_OFFSET, 32'h0);
        chk("readback", exp_word(v), got);
        chk("outputs", {27'h0, v[7:6], v[4] & !i_is_upstream, v[1:0]},
            {27'h0, o_extended_sync, o_common_clock, o_link_disable, o_l1_entry_en, o_l0s_entry_en});
        chk("retrains", exp_rt, rt_cnt);
    endtask : step
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // ****************************************
    // main sequence: downstream, locked and unlocked upstream
    // ****************************************
    initial begin
        void'($urandom(28869));
        {i_clk, i_resetn, i_avs_read, i_avs_write, i_is_upstream, i_eeprom_load} = 6'h00;
        {i_avs_address, i_avs_writedata, i_eeprom_aspm, unlock} = '0;
        i_avs_byteenable = 4'hF;
        {fails, num_checks, rt_cnt, exp_rt, cyc} = '0;
        for (int p = 0; p < 3; p++) begin
            i_resetn <= 1'b0;
            i_is_upstream <= (p != 0);
            unlock = (p == 2);
            repeat (4) @(posedge i_clk);
            i_resetn <= 1'b1;
            @(posedge i_clk);
            bus(1'b0, LINK_CONTROL_OFFSET, 32'h0);
            chk("reset", {16'h0, LINK_CONTROL_RESET}, got);
            if (unlock) bus(1'b1, SWITCH_CONTROL_OFFSET, 32'h1);
            for (int i = 0; i < 12; i++) begin
                d = $urandom;
                d[1:0] = i[1:0];
                if (i == 11) d = 32'hFFFFFFFF;
                step(d);
            end
            bus(1'b1, 12'h123, 32'hFFFFFFFF);
            bus(1'b0, 12'h123, 32'h0);
            chk("unmapped", UNMAPPED_READ_VALUE, got);
            // low byte lane off: the stored fields must not move
            i_avs_byteenable <= 4'hE;
            bus(1'b1, LINK_CONTROL_OFFSET, 32'h00000000);
            i_avs_byteenable <= 4'hF;
            bus(1'b0, LINK_CONTROL_OFFSET, 32'h0);
            chk("byte lanes", exp_word(d), got);
            i_eeprom_load <= 1'b1;
            i_eeprom_aspm <= 2'h2;
            @(posedge i_clk);
            i_eeprom_load <= 1'b0;
            bus(1'b0, LINK_CONTROL_OFFSET, 32'h0);
            chk("eeprom", exp_word(d) & 32'hFFFFFFFC | 32'h00000002, got);
        end
        conclude();
    end
endmodule : tb
